// ---- dv/nsw_tb.sv ----
`timescale 1ns/10ps
module testbench;
   localparam int unsigned EE_CYC = 20;
   localparam int unsigned ER_CYC = 10;
   localparam logic [7:0] A_CTRL = nsw_pkg::NSW_OFF_CTRL;
   localparam logic [7:0] A_KEY = nsw_pkg::NSW_OFF_KEY;
   localparam logic [7:0] A_IRQ = nsw_pkg::NSW_OFF_IRQ;
   localparam logic [7:0] K1 = nsw_pkg::NSW_KEY_FIRST;
   localparam logic [7:0] K2 = nsw_pkg::NSW_KEY_SECOND;
   localparam int WS = nsw_pkg::NSW_CTRL_WRITE_START;
   localparam int CS = nsw_pkg::NSW_CTRL_CFG_SEL;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic code_protect = 1'b0;
   logic row_write_protect = 1'b0;
   nsw_pkg::nsw_mem_cmd_t mem_cmd;
   nsw_pkg::nsw_mem_cmd_t last_cmd;
   logic cpu_stall;
   logic nvm_irq;
   logic err;
   logic [31:0] rd;
   int fails = 0;
   int cmp_count = 0;
   int cmd_cnt = 0;
   int stall_cyc = 0;

   always #5 pclk = ~pclk;

   nsw_sequencer #(
      .EE_WRITE_CYC(EE_CYC),
      .ROW_ERASE_CYC(ER_CYC)
   ) uut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .code_protect(code_protect),
      .row_write_protect(row_write_protect),
      .mem_cmd(mem_cmd),
      .cpu_stall(cpu_stall),
      .nvm_irq(nvm_irq)
   );

   // commands and stall cycles are counted apart from the bus traffic
   always @(posedge pclk) begin
      if (mem_cmd.valid === 1'b1) begin
         cmd_cnt <= cmd_cnt + 1;
         last_cmd <= mem_cmd;
      end
      if (cpu_stall === 1'b1) begin
         stall_cyc <= stall_cyc + 1;
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task end_sim;
      $display("comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the slave
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic in_ee(logic [14:0] a);
      return a >= nsw_pkg::NSW_EE_BASE && a <= nsw_pkg::NSW_EE_TOP;
   endfunction : in_ee

   // whether a fully unlocked start may begin, from the control bits, address and protect inputs
   function automatic logic exp_go(logic [3:0] c, logic [14:0] a,
                                   logic cp, logic wp);
      if (cp || !c[nsw_pkg::NSW_CTRL_WRITE_ALLOW]) return 1'b0;
      if (c[CS] && in_ee(a)) return 1'b1;
      if (!c[nsw_pkg::NSW_CTRL_ERASE_SEL]) return 1'b0;
      if (!c[CS]) return a <= nsw_pkg::NSW_FLASH_TOP && !wp;
      return a <= nsw_pkg::NSW_UID_TOP;
   endfunction : exp_go

   task automatic run_op(input logic [3:0] c, input logic [14:0] a,
                         input logic cp, input logic wp, input logic [7:0] pre,
                         input logic [7:0] k1, input logic [7:0] k2,
                         input logic brk);
      logic [7:0] d;
      logic ie;
      logic go;
      logic ee;
      logic span;
      int n;
      d = 8'($urandom);
      ie = 1'($urandom);
      go = exp_go(c, a, cp, wp) && k1 === K1 && k2 === K2 && !brk;
      ee = c[CS] && in_ee(a);
      @(posedge pclk);
      code_protect <= cp;
      row_write_protect <= wp;
      cmd_cnt = 0;
      stall_cyc = 0;
      apb(1'b1, A_IRQ, {30'h0, ie, 1'b0});
      apb(1'b1, nsw_pkg::NSW_OFF_ADDR_HI, {25'h0, a[14:8]});
      apb(1'b1, nsw_pkg::NSW_OFF_ADDR_LO, {24'h0, a[7:0]});
      apb(1'b1, nsw_pkg::NSW_OFF_DATA_LO, {24'h0, d});
      apb(1'b1, A_CTRL, {28'h0, c});
      apb(1'b1, A_KEY, {24'h0, pre});
      apb(1'b1, A_KEY, {24'h0, k1});
      if (brk) apb(1'b1, nsw_pkg::NSW_OFF_ADDR_LO, {24'h0, a[7:0]});
      apb(1'b1, A_KEY, {24'h0, k2});
      apb(1'b1, A_CTRL, {28'h0, c} | (32'h1 << WS));
      #1;
      chk(mem_cmd.valid, go, "command pulse");
      chk(cpu_stall, go && !ee, "stall at start");
      apb(1'b1, A_CTRL, {28'h0, c});
      apb(1'b0, A_CTRL, 32'h0);
      chk(rd[WS], go, "start bit");
      n = 0;
      while (rd[WS] === 1'b1 && n < 100) begin
         apb(1'b0, A_CTRL, 32'h0);
         n++;
      end
      chk(rd[3:0], c, "control kept");
      chk(cmd_cnt, go, "command count");
      if (go) begin
         chk(last_cmd.ee_write, ee, "command kind");
         chk(last_cmd.addr, a, "command address");
         if (ee) chk(last_cmd.data, d, "byte data");
         else chk(last_cmd.uid_space, c[CS], "erase space");
      end
      span = stall_cyc >= ER_CYC - 1 && stall_cyc <= ER_CYC + 1;
      chk(go && !ee ? span : stall_cyc == 0, 1'b1, "stall span");
      apb(1'b0, A_IRQ, 32'h0);
      chk(rd[2:0], {1'b0, ie, go}, "status");
      chk(nvm_irq, go && ie, "irq line");
      apb(1'b1, A_IRQ, {30'h0, ie, 1'b0});
      #1;
      chk(nvm_irq, 1'b0, "irq after clear");
      $display("op at %h ctrl %h done", a, c);
   endtask : run_op

   initial begin
      #500000;
      fails++;
      $display("watchdog expired");
      end_sim;
   end

   initial begin
      logic [14:0] a;
      logic [3:0] c;
      int cls;
      void'($urandom(31561));
      repeat (12) @(posedge pclk);
      chk(mem_cmd, 26'h0, "command in reset");
      chk({cpu_stall, nvm_irq, pready}, 3'h1, "outputs in reset");
      presetn <= 1'b1;
      apb(1'b0, A_CTRL, 32'h0);
      chk(rd, 32'h0, "control reset");
      apb(1'b0, A_IRQ, 32'h0);
      chk(rd, 32'h0, "status reset");
      apb(1'b0, 8'h1C, 32'h0);
      chk(err, 1'b1, "unmapped error");
      chk(rd, 32'h0, "unmapped read");
      // corners: bounds of each space, refusals and broken unlocks
      run_op(4'hA, 15'h70FF, 1'b0, 1'b0, 8'h00, K1, K2, 1'b0);
      run_op(4'hA, 15'h7100, 1'b0, 1'b0, 8'h00, K1, K2, 1'b0);
      run_op(4'h8, 15'h7000, 1'b0, 1'b0, 8'h00, K1, K2, 1'b0);
      run_op(4'h3, 15'h17FF, 1'b0, 1'b0, 8'h00, K1, K2, 1'b0);
      run_op(4'h3, 15'h1800, 1'b0, 1'b0, 8'h00, K1, K2, 1'b0);
      run_op(4'h3, 15'h0000, 1'b0, 1'b1, 8'h00, K1, K2, 1'b0);
      run_op(4'hB, 15'h0003, 1'b0, 1'b0, 8'h00, K1, K2, 1'b0);
      run_op(4'hB, 15'h0004, 1'b0, 1'b0, 8'h00, K1, K2, 1'b0);
      run_op(4'hB, 15'h0005, 1'b0, 1'b0, 8'h00, K1, K2, 1'b0);
      run_op(4'hA, 15'h7010, 1'b1, 1'b0, 8'h00, K1, K2, 1'b0);
      run_op(4'hA, 15'h7020, 1'b0, 1'b0, K1, K1, K2, 1'b0);
      run_op(4'hA, 15'h7030, 1'b0, 1'b0, 8'h00, K2, K1, 1'b0);
      run_op(4'hA, 15'h7040, 1'b0, 1'b0, 8'h00, K1, K2, 1'b1);
      run_op(4'h2, 15'h0040, 1'b0, 1'b0, 8'h00, K1, K2, 1'b0);
      $display("corner test done");
      for (int i = 0; i < 40; i++) begin
         cls = $urandom_range(3, 0);
         a = 15'($urandom);
         if (cls == 0) a = nsw_pkg::NSW_EE_BASE | 15'($urandom_range(255, 0));
         if (cls == 1) a = 15'($urandom_range(nsw_pkg::NSW_FLASH_TOP, 0));
         if (cls == 2) a = 15'($urandom_range(10, 0));
         c = {1'($urandom), 1'b0, 1'($urandom_range(9, 0) != 0), 1'($urandom)};
         run_op(c, a, $urandom_range(9, 0) == 0, 1'($urandom), 8'h00, K1, K2,
                1'b0);
      end
      $display("random test done");
      end_sim;
   end
endmodule : testbench

// ---- rtl/nsw_op_timer.sv ----
`timescale 1ns/10ps
module nsw_op_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [nsw_pkg::NSW_TMR_W-1:0] load_val,
   output logic busy,
   output logic done
);
   logic [nsw_pkg::NSW_TMR_W-1:0] cnt_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= load_val;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign busy = (cnt_q != '0);
   // last cycle of the count; load is never seen while busy
   assign done = (cnt_q == {{(nsw_pkg::NSW_TMR_W-1){1'b0}}, 1'b1});
endmodule : nsw_op_timer

// ---- rtl/nsw_pkg.sv ----
package nsw_pkg;
   localparam logic [7:0] NSW_OFF_CTRL = 8'h00;
   localparam logic [7:0] NSW_OFF_KEY = 8'h04;
   localparam logic [7:0] NSW_OFF_ADDR_LO = 8'h08;
   localparam logic [7:0] NSW_OFF_ADDR_HI = 8'h0C;
   localparam logic [7:0] NSW_OFF_DATA_LO = 8'h10;
   localparam logic [7:0] NSW_OFF_DATA_HI = 8'h14;
   localparam logic [7:0] NSW_OFF_IRQ = 8'h18;

   // control register fields
   localparam int NSW_CTRL_ERASE_SEL = 0;
   localparam int NSW_CTRL_WRITE_ALLOW = 1;
   localparam int NSW_CTRL_WRITE_START = 2;
   localparam int NSW_CTRL_CFG_SEL = 3;
   // interrupt/status register fields
   localparam int NSW_IRQ_DONE_FLAG = 0;
   localparam int NSW_IRQ_DONE_IE = 1;
   localparam int NSW_IRQ_BUSY = 2;

   localparam logic [7:0] NSW_KEY_FIRST = 8'h55;
   localparam logic [7:0] NSW_KEY_SECOND = 8'hAA;

   localparam logic [14:0] NSW_FLASH_TOP = 15'h17FF;
   localparam logic [14:0] NSW_UID_TOP = 15'h0003;
   localparam logic [14:0] NSW_EE_BASE = 15'h7000;
   localparam logic [14:0] NSW_EE_TOP = 15'h70FF;

   localparam logic [7:0] NSW_RST_BYTE = 8'h00;
   localparam logic [31:0] NSW_RST_WORD = 32'h0000_0000;

   localparam int NSW_CLK_NS = 10;
   localparam int NSW_EE_WRITE_US = 4000;
   localparam int NSW_ROW_ERASE_US = 2000;
   localparam int NSW_EE_WRITE_CYC = NSW_EE_WRITE_US * 1000 / NSW_CLK_NS;
   localparam int NSW_ROW_ERASE_CYC = NSW_ROW_ERASE_US * 1000 / NSW_CLK_NS;
   localparam int NSW_TMR_W = 20;

   typedef enum logic [1:0] {
      NSW_KEY_IDLE,
      NSW_KEY_GOT_FIRST,
      NSW_KEY_ARMED
   } nsw_key_t;

   typedef enum logic [1:0] {
      NSW_OP_IDLE,
      NSW_OP_EE,
      NSW_OP_ERASE
   } nsw_op_t;

   typedef struct packed {
      logic valid;
      logic ee_write;
      logic uid_space;
      logic [14:0] addr;
      logic [7:0] data;
   } nsw_mem_cmd_t;
endpackage : nsw_pkg

// ---- rtl/nsw_sequencer.sv ----
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module nsw_sequencer #(
   parameter int unsigned EE_WRITE_CYC = nsw_pkg::NSW_EE_WRITE_CYC,
   parameter int unsigned ROW_ERASE_CYC = nsw_pkg::NSW_ROW_ERASE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic code_protect,
   input wire logic row_write_protect,
   output nsw_pkg::nsw_mem_cmd_t mem_cmd,
   output logic cpu_stall,
   output logic nvm_irq
);
   nsw_pkg::nsw_key_t key_q;
   nsw_pkg::nsw_op_t op_q;
   nsw_pkg::nsw_mem_cmd_t mem_cmd_q;
   logic erase_sel_q;
   logic write_allow_q;
   logic write_start_q;
   logic config_space_select_q;
   logic [7:0] nvm_addr_low_q;
   logic [6:0] nvm_addr_high_q;
   logic [7:0] nvm_data_low_q;
   logic [5:0] nvm_data_high_q;
   logic nvm_done_flag_q;
   logic nvm_done_irq_enable_q;
   logic [31:0] prdata_q;

   logic mapped;
   logic wr_acc;
   logic rd_setup;
   logic ctrl_wr;
   logic key_wr;
   logic irq_wr;
   logic [14:0] tgt_addr;
   logic new_cfg;
   logic new_erase;
   logic new_allow;
   logic go_req;
   logic legal_go;
   logic ee_hit;
   logic uid_hit;
   logic flash_hit;
   logic start_ee;
   logic start_erase;
   logic op_start;
   logic tmr_busy;
   logic tmr_done;
   logic [nsw_pkg::NSW_TMR_W-1:0] tmr_val;

   // ---------------- bus decode ----------------
   always_comb begin
      unique case (paddr)
         nsw_pkg::NSW_OFF_CTRL,
         nsw_pkg::NSW_OFF_KEY,
         nsw_pkg::NSW_OFF_ADDR_LO,
         nsw_pkg::NSW_OFF_ADDR_HI,
         nsw_pkg::NSW_OFF_DATA_LO,
         nsw_pkg::NSW_OFF_DATA_HI,
         nsw_pkg::NSW_OFF_IRQ: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // zero wait states: read data is captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign wr_acc = psel & penable & pwrite & mapped;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign ctrl_wr = wr_acc & (paddr == nsw_pkg::NSW_OFF_CTRL);
   assign key_wr = wr_acc & (paddr == nsw_pkg::NSW_OFF_KEY);
   assign irq_wr = wr_acc & (paddr == nsw_pkg::NSW_OFF_IRQ);

   assign tgt_addr = {nvm_addr_high_q, nvm_addr_low_q};
   assign new_cfg = pwdata[nsw_pkg::NSW_CTRL_CFG_SEL];
   assign new_erase = pwdata[nsw_pkg::NSW_CTRL_ERASE_SEL];
   assign new_allow = pwdata[nsw_pkg::NSW_CTRL_WRITE_ALLOW];

   // ---------------- unlock tracking ----------------
   // first key write, then second key arms; any other mapped write returns to idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_q <= nsw_pkg::NSW_KEY_IDLE;
      end else if (wr_acc) begin
         if (key_wr && pwdata[7:0] == nsw_pkg::NSW_KEY_FIRST) begin
            key_q <= nsw_pkg::NSW_KEY_GOT_FIRST;
         end else if (key_wr && key_q == nsw_pkg::NSW_KEY_GOT_FIRST &&
                      pwdata[7:0] == nsw_pkg::NSW_KEY_SECOND) begin
            key_q <= nsw_pkg::NSW_KEY_ARMED;
         end else begin
            key_q <= nsw_pkg::NSW_KEY_IDLE;
         end
      end
   end

   // ---------------- start qualification ----------------
   // start only from the armed key state
   assign go_req = ctrl_wr & pwdata[nsw_pkg::NSW_CTRL_WRITE_START] &
                   (key_q == nsw_pkg::NSW_KEY_ARMED) &
                   (op_q == nsw_pkg::NSW_OP_IDLE);
   assign legal_go = go_req & new_allow & ~code_protect;

   assign ee_hit = new_cfg & (tgt_addr >= nsw_pkg::NSW_EE_BASE) &
                   (tgt_addr <= nsw_pkg::NSW_EE_TOP);
   assign uid_hit = new_cfg & new_erase &
                    (tgt_addr <= nsw_pkg::NSW_UID_TOP);
   assign flash_hit = ~new_cfg & new_erase &
                      (tgt_addr <= nsw_pkg::NSW_FLASH_TOP);

   assign start_ee = legal_go & ee_hit;
   // only erase-select starts a row erase
   assign start_erase = legal_go &
                        (uid_hit | (flash_hit & ~row_write_protect));
   assign op_start = start_ee | start_erase;

   assign tmr_val = start_ee ? EE_WRITE_CYC[nsw_pkg::NSW_TMR_W-1:0]
                             : ROW_ERASE_CYC[nsw_pkg::NSW_TMR_W-1:0];

   nsw_op_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .load(op_start),
      .load_val(tmr_val),
      .busy(tmr_busy),
      .done(tmr_done)
   );

   // ---------------- operation state ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_q <= nsw_pkg::NSW_OP_IDLE;
      end else begin
         unique case (op_q)
            nsw_pkg::NSW_OP_IDLE: begin
               if (start_ee) begin
                  op_q <= nsw_pkg::NSW_OP_EE;
               end else if (start_erase) begin
                  op_q <= nsw_pkg::NSW_OP_ERASE;
               end
            end
            nsw_pkg::NSW_OP_EE,
            nsw_pkg::NSW_OP_ERASE: begin
               if (tmr_done) begin
                  op_q <= nsw_pkg::NSW_OP_IDLE;
               end
            end
            default: op_q <= nsw_pkg::NSW_OP_IDLE;
         endcase
      end
   end

   // EEPROM write lets the CPU run
   assign cpu_stall = (op_q == nsw_pkg::NSW_OP_ERASE);

   // ---------------- control register ----------------
   // write-allow only changes by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         erase_sel_q <= 1'b0;
         write_allow_q <= 1'b0;
         config_space_select_q <= 1'b0;
      end else if (ctrl_wr) begin
         erase_sel_q <= new_erase;
         write_allow_q <= new_allow;
         config_space_select_q <= new_cfg;
      end
   end

   // software cannot clear an active write-start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_start_q <= 1'b0;
      end else if (op_start) begin
         write_start_q <= 1'b1;
      end else if (tmr_done) begin
         write_start_q <= 1'b0;
      end
   end

   // ---------------- address and data ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nvm_addr_low_q <= nsw_pkg::NSW_RST_BYTE;
         nvm_addr_high_q <= nsw_pkg::NSW_RST_BYTE[6:0];
         nvm_data_low_q <= nsw_pkg::NSW_RST_BYTE;
         nvm_data_high_q <= nsw_pkg::NSW_RST_BYTE[5:0];
      end else if (wr_acc) begin
         if (paddr == nsw_pkg::NSW_OFF_ADDR_LO) begin
            nvm_addr_low_q <= pwdata[7:0];
         end
         if (paddr == nsw_pkg::NSW_OFF_ADDR_HI) begin
            nvm_addr_high_q <= pwdata[6:0];
         end
         if (paddr == nsw_pkg::NSW_OFF_DATA_LO) begin
            nvm_data_low_q <= pwdata[7:0];
         end
         if (paddr == nsw_pkg::NSW_OFF_DATA_HI) begin
            nvm_data_high_q <= pwdata[5:0];
         end
      end
   end

   // ---------------- completion flag ----------------
   // flag on completion, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nvm_done_flag_q <= 1'b0;
         nvm_done_irq_enable_q <= 1'b0;
      end else begin
         if (tmr_done) begin
            nvm_done_flag_q <= 1'b1;
         end else if (irq_wr && !pwdata[nsw_pkg::NSW_IRQ_DONE_FLAG]) begin
            nvm_done_flag_q <= 1'b0;
         end
         if (irq_wr) begin
            nvm_done_irq_enable_q <= pwdata[nsw_pkg::NSW_IRQ_DONE_IE];
         end
      end
   end

   assign nvm_irq = nvm_done_flag_q & nvm_done_irq_enable_q;

   // ---------------- memory command ----------------
   // erase command carries no latch reset
   // byte comes from the low data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_cmd_q <= '0;
      end else begin
         mem_cmd_q.valid <= op_start;
         if (op_start) begin
            mem_cmd_q.ee_write <= start_ee;
            mem_cmd_q.uid_space <= new_cfg & ~start_ee;
            mem_cmd_q.addr <= tgt_addr;
            mem_cmd_q.data <= nvm_data_low_q;
         end
      end
   end

   assign mem_cmd = mem_cmd_q;

   // ---------------- read data ----------------
   // data pair reads as zero while protected
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= nsw_pkg::NSW_RST_WORD;
      end else if (rd_setup) begin
         prdata_q <= nsw_pkg::NSW_RST_WORD;
         unique case (paddr)
            nsw_pkg::NSW_OFF_CTRL: begin
               prdata_q[nsw_pkg::NSW_CTRL_ERASE_SEL] <= erase_sel_q;
               prdata_q[nsw_pkg::NSW_CTRL_WRITE_ALLOW] <= write_allow_q;
               prdata_q[nsw_pkg::NSW_CTRL_WRITE_START] <= write_start_q;
               prdata_q[nsw_pkg::NSW_CTRL_CFG_SEL] <= config_space_select_q;
            end
            nsw_pkg::NSW_OFF_ADDR_LO: prdata_q[7:0] <= nvm_addr_low_q;
            nsw_pkg::NSW_OFF_ADDR_HI: prdata_q[6:0] <= nvm_addr_high_q;
            nsw_pkg::NSW_OFF_DATA_LO: begin
               if (!code_protect) begin
                  prdata_q[7:0] <= nvm_data_low_q;
               end
            end
            nsw_pkg::NSW_OFF_DATA_HI: begin
               if (!code_protect) begin
                  prdata_q[5:0] <= nvm_data_high_q;
               end
            end
            nsw_pkg::NSW_OFF_IRQ: begin
               prdata_q[nsw_pkg::NSW_IRQ_DONE_FLAG] <= nvm_done_flag_q;
               prdata_q[nsw_pkg::NSW_IRQ_DONE_IE] <= nvm_done_irq_enable_q;
               prdata_q[nsw_pkg::NSW_IRQ_BUSY] <= tmr_busy;
            end
            default: prdata_q <= nsw_pkg::NSW_RST_WORD;
         endcase
      end
   end

   assign prdata = prdata_q;

   // ---------------- checks ----------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_unlock_order:
   assert property (op_start |-> key_q == nsw_pkg::NSW_KEY_ARMED)
   else $error("operation started without full key sequence");

   // the armed state is reached only from the first-key state by a key write
   a_arm_order:
   assert property (key_q == nsw_pkg::NSW_KEY_ARMED &&
                    $past(key_q) != nsw_pkg::NSW_KEY_ARMED
                    |-> $past(key_q) == nsw_pkg::NSW_KEY_GOT_FIRST &&
                    $past(key_wr))
   else $error("armed state reached out of order");

   a_first_key:
   assert property (key_wr && pwdata[7:0] == nsw_pkg::NSW_KEY_FIRST
                    |=> key_q == nsw_pkg::NSW_KEY_GOT_FIRST)
   else $error("first key write not tracked");

   a_broken_seq:
   assert property (key_q != nsw_pkg::NSW_KEY_IDLE && wr_acc && !key_wr
                    |=> key_q == nsw_pkg::NSW_KEY_IDLE)
   else $error("interrupted unlock still armed");

   a_ee_byte:
   assert property (start_ee |=> mem_cmd.valid && mem_cmd.ee_write &&
                    mem_cmd.data == $past(nvm_data_low_q))
   else $error("eeprom command byte wrong");

   a_ee_done:
   assert property (op_q == nsw_pkg::NSW_OP_EE && tmr_done
                    |=> !write_start_q && nvm_done_flag_q && !cpu_stall)
   else $error("eeprom completion not flagged");

   a_wr_hold:
   assert property (op_q == nsw_pkg::NSW_OP_EE && !tmr_done && ctrl_wr
                    |=> write_start_q)
   else $error("write-start cleared by software mid-write");

   a_allow_keep:
   assert property (tmr_done && !ctrl_wr |=> $stable(write_allow_q))
   else $error("write-allow changed at completion");

   a_no_auto_erase:
   assert property (start_erase |-> new_erase)
   else $error("erase started without erase-select");

   a_wp_skip:
   assert property (legal_go && flash_hit && row_write_protect
                    |=> op_q == nsw_pkg::NSW_OP_IDLE && !write_start_q)
   else $error("protected row erase not skipped");

   a_erase_stall:
   assert property (start_erase |=> cpu_stall [*3])
   else $error("cpu not stalled during row erase");

   a_protect_block:
   assert property (code_protect |-> !op_start)
   else $error("operation started while code-protected");

   a_uid_range:
   assert property (op_start && new_cfg && !start_ee
                    |-> tgt_addr <= nsw_pkg::NSW_UID_TOP)
   else $error("config-space erase outside user ids");
endmodule : nsw_sequencer
